// ### logic/aurx_receiver.v
// asynchronous serial receiver with two-entry receive fifo and register port
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "aurx_regs.vh"

module aurx_receiver #(
    parameter DATA_BITS = 8,
    parameter FIFO_DEPTH = 2
) (
    // clock, reset and freeze
    input wire sys_clk,
    input wire reset,
    input wire clkEn,
    // register port
    input wire [2:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdData,
    // serial line and oversample strobe
    input wire serialInputPin,
    input wire sampleTick,
    // status towards the system
    output reg receiveCharFlag,
    output reg irqRequest
);

    // receiver states
    localparam ST_IDLE = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_STOP = 2'h3;

    localparam ENTRY_W = DATA_BITS + 2;

    // majority of three samples
    function vote3;
        input a;
        input b;
        input c;
        begin
            vote3 = (a & b) | (a & c) | (b & c);
        end
    endfunction

    // software-visible configuration
    reg portEnable;
    reg nineBitSelect;
    reg singleEnable;
    reg receiverEnable;
    reg addressDetectEnable;
    reg [7:0] transmitControl;
    reg [7:0] rateControl;
    reg [7:0] rateDivisorLow;
    reg [7:0] rateDivisorHigh;
    reg receiveIrqEnable;
    reg peripheralIrqEnable;
    reg globalIrqEnable;

    // receive engine state
    reg [1:0] rxState;
    reg [3:0] tickCount;
    reg [3:0] bitIndex;
    reg [1:0] sampleHist;
    reg lastLine;
    reg [DATA_BITS:0] receiveShiftReg;
    reg overrunFlag;

    // fifo storage: {frame error, ninth bit, data}
    reg [ENTRY_W-1:0] fifoMem [0:FIFO_DEPTH-1];
    // one-bit pointers: only a depth of two is supported
    reg wrPtr;
    reg rdPtr;
    reg [1:0] fifoCount;

    wire portReset = reset | ~portEnable;
    wire clockedMode = transmitControl[`AURX_TC_CLOCKED_SEL];
    wire rxActive = receiverEnable & ~clockedMode & portEnable;
    wire lastBit = nineBitSelect ? (bitIndex == 4'h8) : (bitIndex == 4'h7);
    // two earlier oversamples and the pin itself form the vote
    wire bitVote = vote3(sampleHist[1], sampleHist[0], serialInputPin);

    wire [ENTRY_W-1:0] topEntry = fifoMem[rdPtr];
    wire fifoEmpty = (fifoCount == 2'h0);
    wire fifoFull = (fifoCount == FIFO_DEPTH);
    wire topFrameErr = fifoEmpty ? 1'b0 : topEntry[ENTRY_W-1];
    wire topNinthBit = fifoEmpty ? 1'b0 : topEntry[ENTRY_W-2];

    // middle of stop bit: character complete this cycle
    // the push shares this cycle with the stop vote; the flag follows one later
    wire stopDone = clkEn & rxActive & sampleTick & (rxState == ST_STOP) & (tickCount == `AURX_FULL_LAST);
    wire stopFrameErr = ~bitVote;
    wire addressReject = addressDetectEnable & nineBitSelect & ~receiveShiftReg[DATA_BITS];
    wire wantPush = stopDone & ~addressReject & ~overrunFlag;
    wire doPush = wantPush & ~fifoFull;
    wire setOverrun = wantPush & fifoFull;
    wire doPop = clkEn & regRead & (regAddr == `AURX_ADDR_RX_DATA) & ~fifoEmpty;
    wire [ENTRY_W-1:0] pushEntry = {stopFrameErr, nineBitSelect & receiveShiftReg[DATA_BITS],
        receiveShiftReg[DATA_BITS-1:0]};

    // configuration writes; port enable itself only sees the hard reset
    always @(posedge sys_clk) begin
        if (reset) begin
            portEnable <= 1'b0;
            nineBitSelect <= 1'b0;
            singleEnable <= 1'b0;
            receiverEnable <= 1'b0;
            addressDetectEnable <= 1'b0;
            transmitControl <= `AURX_RST_TX_CTRL;
            rateControl <= `AURX_RST_RATE_CTRL;
            rateDivisorLow <= `AURX_RST_DIV;
            rateDivisorHigh <= `AURX_RST_DIV;
            receiveIrqEnable <= 1'b0;
            peripheralIrqEnable <= 1'b0;
            globalIrqEnable <= 1'b0;
        end else if (clkEn && regWrite) begin
            case (regAddr)
                `AURX_ADDR_RX_CTRL: begin
                    portEnable <= regWrData[`AURX_RC_PORT_EN];
                    nineBitSelect <= regWrData[`AURX_RC_NINE_SEL];
                    singleEnable <= regWrData[`AURX_RC_SINGLE_EN];
                    receiverEnable <= regWrData[`AURX_RC_RX_EN];
                    addressDetectEnable <= regWrData[`AURX_RC_ADDR_DET];
                end
                `AURX_ADDR_DIV_LOW: rateDivisorLow <= regWrData;
                `AURX_ADDR_DIV_HIGH: rateDivisorHigh <= regWrData;
                // only polarity, wide divisor, wake and auto-rate bits are writable
                `AURX_ADDR_RATE_CTRL: rateControl <= regWrData & 8'h1B;
                // shift-empty status is not stored here
                `AURX_ADDR_TX_CTRL: transmitControl <= regWrData & 8'hFD;
                `AURX_ADDR_IRQ_EN: begin
                    receiveIrqEnable <= regWrData[`AURX_IE_RECEIVE];
                    peripheralIrqEnable <= regWrData[`AURX_IE_PERIPH];
                    globalIrqEnable <= regWrData[`AURX_IE_GLOBAL];
                end
                default: begin
                end
            endcase
        end
    end

    // sample history and line level at the previous oversample
    // lastLine resets high so leaving reset never fakes a falling edge
    always @(posedge sys_clk) begin
        if (portReset) begin
            sampleHist <= 2'h3;
            lastLine <= 1'b1;
        end else if (clkEn && sampleTick) begin
            sampleHist <= {sampleHist[0], serialInputPin};
            lastLine <= serialInputPin;
        end
    end

    // receive state machine, advances only on oversample strobes
    // port disable resets engine
    always @(posedge sys_clk) begin
        if (portReset || !rxActive) begin
            rxState <= ST_IDLE;
            tickCount <= 4'h0;
            bitIndex <= 4'h0;
            receiveShiftReg <= {(DATA_BITS+1){1'b0}};
        end else if (clkEn && sampleTick) begin
            case (rxState)
                ST_IDLE: begin
                    tickCount <= 4'h0;
                    bitIndex <= 4'h0;
                    if (lastLine && !serialInputPin) begin
                        rxState <= ST_START;
                    end
                end
                ST_START: begin
                    tickCount <= tickCount + 4'h1;
                    if (tickCount == `AURX_HALF_LAST) begin
                        tickCount <= 4'h0;
                        // a glitch aborts quietly, no error recorded
                        rxState <= bitVote ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    tickCount <= tickCount + 4'h1;
                    if (tickCount == `AURX_FULL_LAST) begin
                        // first bit lands in bit zero
                        receiveShiftReg[bitIndex] <= bitVote;
                        bitIndex <= bitIndex + 4'h1;
                        if (lastBit) begin
                            rxState <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    tickCount <= tickCount + 4'h1;
                    if (tickCount == `AURX_FULL_LAST) begin
                        // back to edge search; a new edge needs the line high first
                        rxState <= ST_IDLE;
                        tickCount <= 4'h0;
                    end
                end
                default: rxState <= ST_IDLE;
            endcase
        end
    end

    // fifo storage: one writer per entry
    // whole character moved at once
    genvar gi;
    generate
        for (gi = 0; gi < FIFO_DEPTH; gi = gi + 1) begin : gEntry
            always @(posedge sys_clk) begin
                if (portReset) begin
                    fifoMem[gi] <= {ENTRY_W{1'b0}};
                end else if (doPush && (wrPtr == gi)) begin
                    fifoMem[gi] <= pushEntry;
                end
            end
        end
    endgenerate

    // fifo pointers and occupancy; push and pop may share a cycle
    // port disable empties fifo
    always @(posedge sys_clk) begin
        if (portReset) begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            fifoCount <= 2'h0;
        end else begin
            if (doPush) begin
                wrPtr <= ~wrPtr;
            end
            if (doPop) begin
                rdPtr <= ~rdPtr;
            end
            if (doPush && !doPop) begin
                fifoCount <= fifoCount + 2'h1;
            end else if (doPop && !doPush) begin
                fifoCount <= fifoCount - 2'h1;
            end
        end
    end

    // overrun: set by a refused character, cleared by disable
    // set and clear never meet: a character needs the receiver enabled
    always @(posedge sys_clk) begin
        if (portReset) begin
            overrunFlag <= 1'b0;
        end else if (clkEn) begin
            if (!receiverEnable) begin
                overrunFlag <= 1'b0;
            end else if (setOverrun) begin
                overrunFlag <= 1'b1;
            end
        end
    end

    // read data mux; the value stands only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (reset) begin
            regRdData <= 8'h00;
        end else if (clkEn) begin
            regRdData <= 8'h00;
            if (regRead) begin
                case (regAddr)
                    `AURX_ADDR_RX_CTRL: regRdData <= {portEnable, nineBitSelect, singleEnable,
                        receiverEnable, addressDetectEnable,
                        topFrameErr, overrunFlag, topNinthBit};
                    // an empty fifo shows a stale entry and pops nothing
                    `AURX_ADDR_RX_DATA: regRdData <= topEntry[7:0];
                    `AURX_ADDR_DIV_LOW: regRdData <= rateDivisorLow;
                    `AURX_ADDR_DIV_HIGH: regRdData <= rateDivisorHigh;
                    // idle status follows the engine, not the line
                    `AURX_ADDR_RATE_CTRL: regRdData <= rateControl | {1'b0, rxState == ST_IDLE, 6'h00};
                    // no transmitter here, so its shift register always reads empty
                    `AURX_ADDR_TX_CTRL: regRdData <= transmitControl | 8'h02;
                    `AURX_ADDR_IRQ_EN: regRdData <= {globalIrqEnable, peripheralIrqEnable,
                        receiveIrqEnable, 5'h00};
                    `AURX_ADDR_FLAGS: regRdData <= {2'h0, receiveCharFlag, 5'h00};
                    default: regRdData <= 8'h00;
                endcase
            end
        end
    end

    // receive flag and interrupt request, both registered
    // framing and overrun errors never reach the request on their own
    // one cycle of lag behind the fifo, traded for outputs straight from flops
    always @(posedge sys_clk) begin
        if (reset) begin
            receiveCharFlag <= 1'b0;
            irqRequest <= 1'b0;
        end else if (clkEn) begin
            receiveCharFlag <= receiverEnable & portEnable & ~fifoEmpty;
            irqRequest <= receiverEnable & portEnable & ~fifoEmpty & receiveIrqEnable &
                peripheralIrqEnable & globalIrqEnable;
        end
    end

endmodule // aurx_receiver
`default_nettype wire

// ### logic/aurx_regs.vh
// register map, field positions, reset values and timing counts of the serial receiver
`ifndef AURX_REGS_VH
`define AURX_REGS_VH

// register indices on the 3-bit register port
`define AURX_ADDR_RX_CTRL 3'h0
`define AURX_ADDR_RX_DATA 3'h1
`define AURX_ADDR_DIV_LOW 3'h2
`define AURX_ADDR_DIV_HIGH 3'h3
`define AURX_ADDR_RATE_CTRL 3'h4
`define AURX_ADDR_TX_CTRL 3'h5
`define AURX_ADDR_IRQ_EN 3'h6
`define AURX_ADDR_FLAGS 3'h7

// receive_control_status fields
`define AURX_RC_PORT_EN 7
`define AURX_RC_NINE_SEL 6
`define AURX_RC_SINGLE_EN 5
`define AURX_RC_RX_EN 4
`define AURX_RC_ADDR_DET 3
`define AURX_RC_FRAME_ERR 2
`define AURX_RC_OVERRUN 1
`define AURX_RC_NINTH_BIT 0

// transmit_control_status fields seen by the receiver
`define AURX_TC_CLOCKED_SEL 4
`define AURX_TC_SHIFT_EMPTY 1

// rate_control fields
`define AURX_RT_RX_IDLE 6
`define AURX_RT_WIDE_DIV 3

// interrupt enable register fields
`define AURX_IE_GLOBAL 7
`define AURX_IE_PERIPH 6
`define AURX_IE_RECEIVE 5

// flag register field
`define AURX_FL_RX_CHAR 5

// reset values
`define AURX_RST_RX_CTRL 8'h00
`define AURX_RST_TX_CTRL 8'h00
`define AURX_RST_RATE_CTRL 8'h00
`define AURX_RST_DIV 8'h00
`define AURX_RST_IRQ_EN 8'h00

// oversampling: sixteen samples per bit, mid-bit at sample eight
`define AURX_OVERSAMPLE 16
`define AURX_HALF_LAST 4'h7
`define AURX_FULL_LAST 4'hF

`endif

// ### tb/aurx_line_tx.sv
// behavioural far-end transmitter on the receive line, sixteen ticks a bit
`timescale 1ns/1ps
`default_nettype none
module aurx_line_tx (
    // clock and oversample strobe
    input wire logic sys_clk,
    input wire logic sampleTick,
    // frame request, bit 0 first
    input wire logic go,
    input wire logic glitch,
    input wire logic [10:0] frame,
    input wire logic [3:0] bitCount,
    // line and status
    output logic serialLine,
    output logic busy
);
    logic [10:0] shift = 11'h7FF;
    logic [3:0] left = 4'h0;
    logic [3:0] tick = 4'h0;
    initial busy = 1'h0;
    // low start, then lsb first; a glitch keeps the start only four ticks
    always @(posedge sys_clk) begin
        if (go && !busy) begin
            shift <= frame;
            left <= bitCount;
            tick <= glitch ? 4'hC : 4'h0;
            busy <= 1'h1;
        end else if (busy && sampleTick) begin
            tick <= tick + 4'h1;
            if (tick == 4'hF) begin
                shift <= {1'h1, shift[10:1]};
                left <= left - 4'h1;
                busy <= (left != 4'h1);
            end
        end
    end
    // released line rests at the idle mark level
    assign serialLine = busy ? shift[0] : 1'h1;
endmodule // aurx_line_tx
`default_nettype wire

// ### tb/aurx_receiver_props.sv
// assertion checker for the serial receiver register port and status outputs
`timescale 1ns/1ps
`default_nettype none
module aurx_receiver_props (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // register port
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    // line strobe and status
    input wire logic sampleTick,
    input wire logic receiveCharFlag,
    input wire logic irqRequest
);
    logic [7:0] cfg;
    wire logic live;
    wire logic popReq;
    // shadow of the written control bits, status bits unused
    always @(posedge sys_clk) begin
        if (reset)
            cfg <= 8'h00;
        else if (regWrite && regAddr == 3'h0)
            cfg <= regWrData;
    end
    // flag has one cycle of lag, so causes are looked for one or two edges back
    assign live = cfg[7] && cfg[4];
    assign popReq = regRead && regAddr == 3'h1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    irq_flag_a: assert property (irqRequest |-> receiveCharFlag)
        else $error("irq request without receive flag");
    irq_rise_a: assert property ($rose(irqRequest) |-> $rose(receiveCharFlag)
        || $past(regWrite) || $past(regWrite, 2))
        else $error("irq rose without flag or enable write");
    flag_rise_a: assert property ($rose(receiveCharFlag) |-> $past(sampleTick) || $past(sampleTick, 2)
        || $past(regWrite) || $past(regWrite, 2))
        else $error("receive flag rose without a push");
    flag_fall_a: assert property ($fell(receiveCharFlag) |-> $past(popReq) || $past(popReq, 2)
        || $past(regWrite) || $past(regWrite, 2))
        else $error("receive flag fell without read or disable");
    flag_off_a: assert property (!live && !$past(live) |-> !receiveCharFlag)
        else $error("receive flag high while disabled");
    cfg_read_a: assert property (regRead && regAddr == 3'h0 |=> regRdData[7:3] == cfg[7:3])
        else $error("control bits read back wrong");
    status_off_a: assert property (regRead && regAddr == 3'h0 && !cfg[7] && !$past(cfg[7])
        |=> regRdData[2:0] == 3'h0)
        else $error("status bits set while port disabled");
    ovr_clear_a: assert property (regRead && regAddr == 3'h0 && !cfg[4] && !$past(cfg[4])
        |=> !regRdData[1])
        else $error("overrun set while receiver disabled");
    rd_idle_a: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data outside answer cycle");
endmodule // aurx_receiver_props
bind aurx_receiver aurx_receiver_props aurx_receiver_props_i (.sys_clk(sys_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .sampleTick(sampleTick), .receiveCharFlag(receiveCharFlag), .irqRequest(irqRequest));
`default_nettype wire

// ### tb/aurx_receiver_tb_top.sv
// self-checking bench for the serial receiver: frames, register reads, flags
`timescale 1ns/1ps
`default_nettype none
module aurx_receiver_tb_top;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'h0;
    logic regRead = 1'h0;
    logic sampleTick = 1'h0;
    logic [1:0] tickDiv = 2'h0;
    logic go = 1'h0;
    logic glitch = 1'h0;
    logic [10:0] frame = 11'h7FF;
    logic [3:0] bitCount = 4'h0;
    logic rdSeen = 1'h0;
    logic flagLook = 1'h0;
    wire logic serialLine, busy, receiveCharFlag, irqRequest;
    wire logic [7:0] regRdData;
    logic [7:0] expQ[$];
    logic [1:0] flagQ[$];
    logic [7:0] dq [0:2];
    integer fails = 0;
    integer total_checks = 0;
    integer seed = 32'hB9810FFD;
    integer i;
    aurx_receiver aurx_receiver_i (.sys_clk(sys_clk), .reset(reset), .clkEn(1'h1), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .serialInputPin(serialLine), .sampleTick(sampleTick), .receiveCharFlag(receiveCharFlag),
        .irqRequest(irqRequest));
    aurx_line_tx aurx_line_tx_i (.sys_clk(sys_clk), .sampleTick(sampleTick), .go(go), .glitch(glitch),
        .frame(frame), .bitCount(bitCount), .serialLine(serialLine), .busy(busy));
    // clock, and a tick every fourth cycle to keep frames short
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        tickDiv <= tickDiv + 2'h1;
        sampleTick <= (tickDiv == 2'h3);
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // read answers stand one cycle only, so compare at the next edge; flag notes likewise
    always @(posedge sys_clk) begin
        if (rdSeen)
            check(regRdData, expQ.pop_front());
        if (flagLook)
            check({6'h00, receiveCharFlag, irqRequest}, {6'h00, flagQ.pop_front()});
        rdSeen <= regRead;
    end
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'h1;
        @(posedge sys_clk);
        regWrite <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        expQ.push_back(e);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge sys_clk);
        regRead <= 1'h0;
        @(posedge sys_clk);
    endtask
    // whole frame from the far end, waited out under a bound
    task automatic send(input logic [8:0] d, input logic nine, input logic stopB, input logic gl);
        integer n;
        frame <= nine ? {stopB, d, 1'h0} : {1'h1, stopB, d[7:0], 1'h0};
        bitCount <= gl ? 4'h1 : (nine ? 4'hB : 4'hA);
        glitch <= gl;
        go <= 1'h1;
        @(posedge sys_clk);
        go <= 1'h0;
        @(posedge sys_clk);
        for (n = 0; n < 4000 && busy; n++) @(posedge sys_clk);
        // a frame that never ends counts against the run
        if (busy)
            fails++;
    endtask
    // note the expected flag pair; the watcher compares it at the next edge
    task automatic flags(input logic f, input logic q);
        flagQ.push_back({f, q});
        flagLook <= 1'h1;
        @(posedge sys_clk);
        flagLook <= 1'h0;
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'h0;
        @(posedge sys_clk);
        rd(3'h0, 8'h00);
        rd(3'h5, 8'h02);
        wr(3'h6, 8'hE0);
        wr(3'h0, 8'h90);
        // clocked mode and a short start must both be ignored
        wr(3'h5, 8'h10);
        send(9'h055, 1'h0, 1'h1, 1'h0);
        flags(1'h0, 1'h0);
        wr(3'h5, 8'h00);
        send(9'h000, 1'h0, 1'h1, 1'h1);
        flags(1'h0, 1'h0);
        for (i = 0; i < 2; i++) begin
            dq[i] = $random(seed);
            send({1'h0, dq[i]}, 1'h0, i == 0, 1'h0);
        end
        flags(1'h1, 1'h1);
        rd(3'h7, 8'h20);
        rd(3'h0, 8'h90);
        rd(3'h1, dq[0]);
        rd(3'h0, 8'h94);
        rd(3'h1, dq[1]);
        flags(1'h0, 1'h0);
        // third character into a full fifo, then a blocked fourth
        for (i = 0; i < 3; i++) begin
            dq[i] = $random(seed);
            send({1'h0, dq[i]}, 1'h0, 1'h1, 1'h0);
        end
        rd(3'h0, 8'h92);
        rd(3'h1, dq[0]);
        rd(3'h1, dq[1]);
        send(9'h0A5, 1'h0, 1'h1, 1'h0);
        flags(1'h0, 1'h0);
        wr(3'h0, 8'h80);
        rd(3'h0, 8'h80);
        // partial irq enables, framing tag kept over receiver disable
        wr(3'h6, 8'hC0);
        wr(3'h0, 8'h90);
        send(9'h03C, 1'h0, 1'h0, 1'h0);
        flags(1'h1, 1'h0);
        wr(3'h0, 8'h80);
        flags(1'h0, 1'h0);
        rd(3'h0, 8'h84);
        wr(3'h0, 8'h10);
        rd(3'h0, 8'h10);
        // address detect drops a data character and keeps an address
        wr(3'h0, 8'hD8);
        send(9'h066, 1'h1, 1'h1, 1'h0);
        send(9'h1C3, 1'h1, 1'h1, 1'h0);
        rd(3'h0, 8'hD9);
        rd(3'h1, 8'hC3);
        wr(3'h0, 8'hD0);
        send(9'h09A, 1'h1, 1'h1, 1'h0);
        rd(3'h0, 8'hD0);
        rd(3'h1, 8'h9A);
        repeat (4) @(posedge sys_clk);
        final_report;
    end
    // watchdog well beyond the expected run of about 7400 cycles
    initial begin
        #1000000;
        fails++;
        final_report;
    end
endmodule // aurx_receiver_tb_top
`default_nettype wire
